// ==== pkg/stp_pkg.sv ====
// stp_pkg: constants, register map and types of the sync trigger block.
// assumes a 10 MHz system clock and a 32-bit APB register bus.
package stp_pkg;
  localparam int NUM_LINES = 4;
  localparam int LINE_W = 2;
  localparam int CNT_W = 8;
  localparam int MS_W = 7;
  localparam int ADDR_W = 12;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_IN_START = 12'h008;
  localparam logic [11:0] ADDR_IN_STOP = 12'h00C;
  localparam logic [11:0] ADDR_OUT_START = 12'h010;
  localparam logic [11:0] ADDR_OUT_STOP = 12'h014;

  // control bits (start, stop and clear are write-one pulses)
  localparam int CTRL_ARM = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_CLEAR = 3;

  // action configuration fields
  localparam int CFG_LINE_LSB = 0;
  localparam int CFG_EDGE_LSB = 2;
  localparam int CFG_POL_BIT = 2;
  localparam int CFG_EN_BIT = 4;
  localparam int CFG_ONCE_BIT = 5;
  localparam int CFG_FIRST_LSB = 8;
  localparam int CFG_FACTOR_LSB = 16;
  localparam int CFG_WIDTH_LSB = 24;

  // status fields
  localparam int STAT_REC = 0;
  localparam int STAT_START_PEND = 1;
  localparam int STAT_STOP_PEND = 2;
  localparam int STAT_IN_LSB = 8;
  localparam int STAT_OUT_LSB = 12;

  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic CTRL_ARM_RST = 1'b0;

  // input edge selection
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // pulse width limit and millisecond time base
  localparam logic [MS_W-1:0] MS_PULSE_MAX = 7'h63;
  localparam int CLK_PERIOD_NS = 100;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;

  typedef enum logic [3:0] {
    REC_IDLE = 4'h1,
    REC_START_PEND = 4'h2,
    REC_RUN = 4'h4,
    REC_STOP_PEND = 4'h8
  } stp_rec_t;
endpackage

// ==== pkg/stp_occ_if.sv ====
// stp_occ_if: settings, occurrences and verdict of one occurrence filter.
// assumes one clock shared by the controller and the filter.
`timescale 1ns/1ps
`default_nettype none
interface stp_occ_if;
  import stp_pkg::*;
  logic enable;
  logic once;
  logic [CNT_W-1:0] skipFirst;
  logic [CNT_W-1:0] skipFactor;
  logic clear;
  logic occur;
  logic fire;
  modport filt (input enable, once, skipFirst, skipFactor, clear, occur,
    output fire);
  modport ctl (output enable, once, skipFirst, skipFactor, clear, occur,
    input fire);
endinterface
`default_nettype wire

// ==== hw/stp_occ_filter.sv ====
// stp_occ_filter: decides which occurrences of a trigger become actions.
// assumes occur is a one-cycle pulse and clear a session-start pulse.
`timescale 1ns/1ps
`default_nettype none
module stp_occ_filter
  import stp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  stp_occ_if.filt occ
);
  logic [CNT_W-1:0] skipCnt_q;
  logic [CNT_W-1:0] skipCnt_d;
  logic emitted_q;
  logic emitted_d;
  logic fireNow;

  always_comb
  begin
    skipCnt_d = skipCnt_q;
    emitted_d = emitted_q;
    fireNow = 1'b0;
    if (occ.enable && occ.occur)
    begin
      // initial discard first, decimation next, single shot last
      if (!emitted_q)
      begin
        if (skipCnt_q >= occ.skipFirst)
        begin
          fireNow = 1'b1;
          emitted_d = 1'b1;
          skipCnt_d = '0;
        end
        else
        begin
          skipCnt_d = skipCnt_q + 1'b1;
        end
      end
      else if (skipCnt_q >= occ.skipFactor)
      begin
        // once set: only the very first qualifying occurrence acts
        fireNow = !occ.once;
        skipCnt_d = '0;
      end
      else
      begin
        skipCnt_d = skipCnt_q + 1'b1;
      end
    end
    if (occ.clear)
    begin
      skipCnt_d = '0;
      emitted_d = 1'b0;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      skipCnt_q <= '0;
      emitted_q <= 1'b0;
    end
    else
    begin
      skipCnt_q <= skipCnt_d;
      emitted_q <= emitted_d;
    end
  end

  assign occ.fire = fireNow && !occ.clear;
endmodule
`default_nettype wire

// ==== hw/stp_sync_trigger.sv ====
// stp_sync_trigger: trigger inputs that start and stop recording on
// frame boundaries, and trigger outputs that announce start and stop.
// assumes frameTick is a one-cycle pulse on clk_sys at each frame
// boundary; syncIn pins are asynchronous; APB master on clk_sys.
//
// How it works
// - each output action drives its selected line
// - positive: idle low, high during pulse
// - negative: idle high, low during pulse
// - output single shot emits first pulse only
// - skip a set number of initial occurrences
// - skip a set number between emitted pulses
// - pulse width in milliseconds, at most 99
// - width zero keeps the output asserted
// - start recording at next frame boundary
// - stop recording when current frame ends
// - shared line: odd pulses start, even stop
// - pulse output on each recording start, stop
// - input edge: rising, falling or both
// - input single shot acts on first trigger
`timescale 1ns/1ps
`default_nettype none
module stp_sync_trigger
  import stp_pkg::*;
#(
  parameter int MS_DIV = MS_CYCLES
)
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frameTick,
  input wire logic [NUM_LINES-1:0] syncIn,
  output logic [NUM_LINES-1:0] syncOut,
  output logic recording
);
  // filters: 0 input start, 1 input stop, 2 output start, 3 output stop
  stp_occ_if occ [4] ();

  logic ctrlArm_q;
  logic ctrlArm_d;
  logic [31:0] cfg_q [4];
  logic [31:0] cfg_d [4];
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic swStart;
  logic swStop;
  logic sessionClear;
  logic mapped;
  logic setupPhase;
  logic accessWr;

  // ---------------- APB slave: zero wait states ----------------
  assign setupPhase = psel && !penable;
  assign accessWr = psel && penable && pwrite && !pslverr;
  assign pready = 1'b1;
  assign prdata = rdata_q;
  assign pslverr = psel && penable && !mapped;

  always_comb
  begin
    if (paddr == ADDR_CTRL || paddr == ADDR_STATUS)
      mapped = 1'b1;
    else if (paddr >= ADDR_IN_START && paddr <= ADDR_OUT_STOP)
      mapped = (paddr[1:0] == 2'h0);
    else
      mapped = 1'b0;
  end

  logic [NUM_LINES-1:0] inSync1_q;
  logic [NUM_LINES-1:0] inSync2_q;
  logic [NUM_LINES-1:0] inPrev_q;
  logic [NUM_LINES-1:0] syncOut_q;
  stp_rec_t rec_q;
  stp_rec_t rec_d;

  always_comb
  begin
    ctrlArm_d = ctrlArm_q;
    for (int i = 0; i < 4; i++)
      cfg_d[i] = cfg_q[i];
    swStart = 1'b0;
    swStop = 1'b0;
    sessionClear = 1'b0;
    rdata_d = rdata_q;
    if (accessWr)
    begin
      if (paddr == ADDR_CTRL)
      begin
        ctrlArm_d = pwdata[CTRL_ARM];
        swStart = pwdata[CTRL_START];
        swStop = pwdata[CTRL_STOP];
        sessionClear = pwdata[CTRL_CLEAR];
      end
      else if (paddr == ADDR_IN_START)
        cfg_d[0] = pwdata;
      else if (paddr == ADDR_IN_STOP)
        cfg_d[1] = pwdata;
      else if (paddr == ADDR_OUT_START)
        cfg_d[2] = pwdata;
      else if (paddr == ADDR_OUT_STOP)
        cfg_d[3] = pwdata;
    end
    // read data is captured in the setup cycle, ready in the access cycle
    if (setupPhase)
    begin
      rdata_d = '0;
      if (paddr == ADDR_CTRL)
        rdata_d[CTRL_ARM] = ctrlArm_q;
      else if (paddr == ADDR_STATUS)
      begin
        rdata_d[STAT_REC] = recording;
        rdata_d[STAT_START_PEND] = (rec_q == REC_START_PEND);
        rdata_d[STAT_STOP_PEND] = (rec_q == REC_STOP_PEND);
        rdata_d[STAT_IN_LSB +: NUM_LINES] = inSync2_q;
        rdata_d[STAT_OUT_LSB +: NUM_LINES] = syncOut_q;
      end
      else if (paddr == ADDR_IN_START)
        rdata_d = cfg_q[0];
      else if (paddr == ADDR_IN_STOP)
        rdata_d = cfg_q[1];
      else if (paddr == ADDR_OUT_START)
        rdata_d = cfg_q[2];
      else if (paddr == ADDR_OUT_STOP)
        rdata_d = cfg_q[3];
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      ctrlArm_q <= CTRL_ARM_RST;
      for (int i = 0; i < 4; i++)
        cfg_q[i] <= CFG_RST;
      rdata_q <= '0;
    end
    else
    begin
      ctrlArm_q <= ctrlArm_d;
      for (int i = 0; i < 4; i++)
        cfg_q[i] <= cfg_d[i];
      rdata_q <= rdata_d;
    end
  end

  // ---------------- input trigger detection ----------------
  logic [1:0] inEdgeHit;

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      inSync1_q <= '0;
      inSync2_q <= '0;
      inPrev_q <= '0;
    end
    else
    begin
      inSync1_q <= syncIn;
      inSync2_q <= inSync1_q;
      inPrev_q <= inSync2_q;
    end
  end

  always_comb
  begin
    for (int a = 0; a < 2; a++)
    begin
      logic [LINE_W-1:0] sel;
      logic [1:0] edg;
      logic nowLvl;
      logic oldLvl;
      sel = cfg_q[a][CFG_LINE_LSB +: LINE_W];
      edg = cfg_q[a][CFG_EDGE_LSB +: 2];
      nowLvl = inSync2_q[sel];
      oldLvl = inPrev_q[sel];
      inEdgeHit[a] = ((edg == EDGE_RISE || edg == EDGE_BOTH)
                      && nowLvl && !oldLvl)
                     || ((edg == EDGE_FALL || edg == EDGE_BOTH)
                      && !nowLvl && oldLvl);
    end
  end

  // ---------------- recording sequencer ----------------
  logic startReq;
  logic stopReq;
  logic startEvt;
  logic stopEvt;

  // shared-line pairing relies on software programming the counts
  assign startReq = swStart || occ[0].fire;
  assign stopReq = swStop || occ[1].fire;

  always_comb
  begin
    rec_d = rec_q;
    startEvt = 1'b0;
    stopEvt = 1'b0;
    case (rec_q)
      REC_IDLE:
        if (startReq)
          rec_d = REC_START_PEND;
      REC_START_PEND:
        if (frameTick)
        begin
          rec_d = REC_RUN;
          startEvt = 1'b1;
        end
      REC_RUN:
        if (stopReq)
          rec_d = REC_STOP_PEND;
      REC_STOP_PEND:
        if (frameTick)
        begin
          rec_d = REC_IDLE;
          stopEvt = 1'b1;
        end
      default:
        rec_d = REC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
      rec_q <= REC_IDLE;
    else
      rec_q <= rec_d;
  end

  assign recording = (rec_q == REC_RUN) || (rec_q == REC_STOP_PEND);

  // ---------------- occurrence filters ----------------
  logic [3:0] occEvent;
  assign occEvent = {stopEvt, startEvt, inEdgeHit & {2{ctrlArm_q}}};

  for (genvar f = 0; f < 4; f++)
  begin : g_filt
    assign occ[f].enable = cfg_q[f][CFG_EN_BIT];
    assign occ[f].once = cfg_q[f][CFG_ONCE_BIT];
    assign occ[f].skipFirst = cfg_q[f][CFG_FIRST_LSB +: CNT_W];
    assign occ[f].skipFactor = cfg_q[f][CFG_FACTOR_LSB +: CNT_W];
    assign occ[f].clear = sessionClear;
    assign occ[f].occur = occEvent[f];
    stp_occ_filter u_filt (
      .clk_sys(clk_sys),
      .rst(rst),
      .occ(occ[f])
    );
  end

  // ---------------- output pulses ----------------
  logic [15:0] msDiv_q;
  logic [15:0] msDiv_d;
  logic msTick;
  logic [1:0] outFire;
  logic [1:0] act_q;
  logic [1:0] act_d;
  logic [MS_W-1:0] msLeft_q [2];
  logic [MS_W-1:0] msLeft_d [2];
  logic [NUM_LINES-1:0] syncOut_d;

  assign outFire = {occ[3].fire, occ[2].fire};
  assign msTick = (msDiv_q == 16'(MS_DIV - 1));

  always_comb
  begin
    // divider restarts on a new pulse so its first ms is whole
    msDiv_d = (msTick || (|outFire)) ? 16'h0000 : msDiv_q + 16'h0001;
    for (int a = 0; a < 2; a++)
    begin
      logic [MS_W-1:0] w;
      w = cfg_q[a+2][CFG_WIDTH_LSB +: MS_W];
      act_d[a] = act_q[a];
      msLeft_d[a] = msLeft_q[a];
      // zero width never counts down, the line stays asserted
      if (act_q[a] && msLeft_q[a] != '0 && msTick)
      begin
        msLeft_d[a] = msLeft_q[a] - 1'b1;
        if (msLeft_q[a] == 7'h01)
          act_d[a] = 1'b0;
      end
      if (outFire[a])
      begin
        act_d[a] = 1'b1;
        msLeft_d[a] = (w > MS_PULSE_MAX) ? MS_PULSE_MAX : w;
      end
      if (sessionClear)
        act_d[a] = 1'b0;
    end
    for (int l = 0; l < NUM_LINES; l++)
    begin
      logic pol;
      logic asrt;
      pol = 1'b0;
      asrt = 1'b0;
      for (int a = 0; a < 2; a++)
        if (cfg_q[a+2][CFG_EN_BIT]
            && cfg_q[a+2][CFG_LINE_LSB +: LINE_W] == LINE_W'(l))
        begin
          pol = cfg_q[a+2][CFG_POL_BIT];
          asrt = asrt || act_q[a];
        end
      syncOut_d[l] = asrt ^ pol;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      msDiv_q <= '0;
      act_q <= '0;
      msLeft_q[0] <= '0;
      msLeft_q[1] <= '0;
      syncOut_q <= '0;
    end
    else
    begin
      msDiv_q <= msDiv_d;
      act_q <= act_d;
      msLeft_q[0] <= msLeft_d[0];
      msLeft_q[1] <= msLeft_d[1];
      syncOut_q <= syncOut_d;
    end
  end

  assign syncOut = syncOut_q;
endmodule
`default_nettype wire

// ==== bench/stp_sync_trigger_props.sv ====
// stp_sync_trigger_props: port assertions of the trigger block.
// assumes clk_sys only, synchronous active high rst.
`timescale 1ns/1ps
`default_nettype none
module stp_sync_trigger_props
  import stp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frameTick,
  input wire logic [NUM_LINES-1:0] syncIn,
  input wire logic [NUM_LINES-1:0] syncOut,
  input wire logic recording
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  logic acc, bad;
  assign acc = psel && penable;
  assign bad = (paddr > ADDR_OUT_STOP) || (paddr[1:0] != 2'h0);
  a_zero_wait: assert property (acc |-> pready)
    else $error("pready low in access");
  a_refuse_bad: assert property (acc && bad |-> pslverr)
    else $error("no error on unmapped access");
  a_accept_good: assert property (acc && !bad |-> !pslverr)
    else $error("error on mapped access");
  a_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  a_refused_read: assert property (acc && !pwrite && bad |-> prdata == 0)
    else $error("refused read not zero");
  a_rec_on_frame: assert property (
    $changed(recording) && !$past(rst) |-> $past(frameTick))
    else $error("recording moved off a frame boundary");
  a_rec_min_run: assert property ($rose(recording) |-> recording [*2])
    else $error("recording ended mid-frame");
  a_reset_idle: assert property ($fell(rst) |-> syncOut == 0 && !recording)
    else $error("outputs not idle after reset");
endmodule
`default_nettype wire

// ==== bench/stp_sync_partner.sv ====
// stp_sync_partner: far instrument; sends trigger pulses, counts ours.
// assumes its pins are sampled on clk_sys edges.
`timescale 1ns/1ps
`default_nettype none
module stp_sync_partner
  import stp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic [NUM_LINES-1:0] syncOut,
  output logic [NUM_LINES-1:0] syncIn
);
  int riseCnt [NUM_LINES];
  int fallCnt [NUM_LINES];
  int hiLen [NUM_LINES];
  int run [NUM_LINES];
  logic [NUM_LINES-1:0] lastOut = '0;
  initial syncIn = '0;
  // all pulses alike, so meaning comes only from their order
  task automatic pulse(input int line, input int len);
    @(posedge clk_sys);
    syncIn[line] <= 1'b1;
    repeat (len) @(posedge clk_sys);
    syncIn[line] <= 1'b0;
  endtask
  // both edges counted: polarity is judged by the bench
  always @(posedge clk_sys)
  begin
    lastOut <= syncOut;
    for (int l = 0; l < NUM_LINES; l++)
    begin
      if (syncOut[l] === 1'b1 && lastOut[l] === 1'b0)
        riseCnt[l]++;
      if (syncOut[l] === 1'b0 && lastOut[l] === 1'b1)
        fallCnt[l]++;
      if (syncOut[l] === 1'b0 && lastOut[l] === 1'b1)
        hiLen[l] = run[l];
      run[l] = (syncOut[l] === 1'b1) ? run[l] + 1 : 0;
    end
  end
endmodule
`default_nettype wire

// ==== bench/test_stp_sync_trigger.sv ====
// test_stp_sync_trigger: self-checking bench of the trigger block.
// assumes the partner model on the pins; APB driven from here.
`timescale 1ns/1ps
`default_nettype none
module test_stp_sync_trigger;
  import stp_pkg::*;
  localparam int MSD = 10;
  localparam int NOCC = 5;
  logic clk_sys, rst, psel, penable, pwrite, pready, pslverr, err, once;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic frameTick, recording;
  logic [NUM_LINES-1:0] syncIn, syncOut;
  logic [1:0] edges [3];
  int error_cnt, n_compared, fcnt, f, k, w, r1, f2, nExp, hl;

  stp_sync_trigger #(.MS_DIV(MSD)) stp_sync_trigger_i (.clk_sys(clk_sys),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .frameTick(frameTick), .syncIn(syncIn),
    .syncOut(syncOut), .recording(recording));
  stp_sync_partner stp_sync_partner_i (.clk_sys(clk_sys),
    .syncOut(syncOut), .syncIn(syncIn));

  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // frames of 50 cycles, longer than any output pulse set here
  always @(posedge clk_sys)
  begin
    fcnt <= (fcnt == 49) ? 0 : fcnt + 1;
    frameTick <= (fcnt == 49);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1)
      @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_rec(input logic v);
    for (int i = 0; i < 300 && recording !== v; i++)
      @(posedge clk_sys);
    check({31'h0, recording}, {31'h0, v});
  endtask
  function automatic logic [31:0] cfg(input int ln, input logic [1:0] md,
    input logic o, input int fi, input int fa, input int wi);
    return (32'(ln) << CFG_LINE_LSB) | (32'(md) << CFG_EDGE_LSB)
      | (32'h1 << CFG_EN_BIT) | (32'(o) << CFG_ONCE_BIT)
      | (32'(fi) << CFG_FIRST_LSB) | (32'(fa) << CFG_FACTOR_LSB)
      | (32'(wi) << CFG_WIDTH_LSB);
  endfunction
  function automatic int exp_fires(input int n, input int fi, input int fa,
    input logic o);
    int c;
    c = 0;
    for (int i = fi; i < n; i += fa + 1)
      c++;
    return (o && c > 1) ? 1 : c;
  endfunction
  task automatic end_sim;
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial
  begin
    rst = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = '0;
    pwdata = '0;
    edges = '{EDGE_RISE, EDGE_FALL, EDGE_BOTH};
    void'($urandom(32'h004BDD18));
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    check({27'h0, syncOut, recording}, 32'h0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, ADDR_OUT_START, 32'h0);
    check(rd, CFG_RST);
    apb(1'b0, 12'h020, 32'h0);
    check({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h002, 32'hFFFF_FFFF);
    check({31'h0, err}, 32'h1);
    // a refused write must leave the CTRL register untouched
    apb(1'b0, ADDR_CTRL, 32'h0);
    check(rd, 32'h0);
    k = $urandom;
    apb(1'b1, ADDR_IN_STOP, k);
    apb(1'b0, ADDR_IN_STOP, 32'h0);
    check(rd, k);
    $display("test registers done");
    foreach (edges[e])
    begin
      apb(1'b1, ADDR_IN_START, cfg(0, edges[e], 1'b0, 0, 1, 0));
      apb(1'b1, ADDR_IN_STOP, cfg(0, edges[e], 1'b0, 1, 1, 0));
      apb(1'b1, ADDR_CTRL, 32'h9);
      for (int p = 0; p < 2; p++)
      begin
        stp_sync_partner_i.pulse(0, 120);
        repeat (150) @(posedge clk_sys);
        check({31'h0, recording}, {31'h0, p == 0 && e != 2});
      end
    end
    // single-shot start: the second pulse on the start line is ignored
    apb(1'b1, ADDR_IN_START, cfg(0, EDGE_RISE, 1'b1, 0, 0, 0));
    apb(1'b1, ADDR_IN_STOP, cfg(3, EDGE_RISE, 1'b0, 0, 0, 0));
    apb(1'b1, ADDR_CTRL, 32'h9);
    for (int p = 0; p < 3; p++)
    begin
      stp_sync_partner_i.pulse((p == 1) ? 3 : 0, 5);
      repeat (100) @(posedge clk_sys);
      check({31'h0, recording}, {31'h0, p == 0});
    end
    $display("test input triggers done");
    for (int r = 0; r < 3; r++)
    begin
      f = (r == 1) ? NOCC - 1 : $urandom % 3;
      k = $urandom % 3;
      w = 1 + $urandom % 3;
      once = (r == 2) ? 1'b1 : 1'($urandom % 2);
      apb(1'b1, ADDR_OUT_START, cfg(1, 2'h0, once, f, k, w));
      apb(1'b1, ADDR_OUT_STOP, cfg(2, 2'h1, 1'b0, 0, 0, 0));
      apb(1'b1, ADDR_CTRL, 32'h9);
      repeat (3) @(posedge clk_sys);
      check({28'h0, syncOut}, 32'h4);
      r1 = stp_sync_partner_i.riseCnt[1];
      f2 = stp_sync_partner_i.fallCnt[2];
      for (int n = 0; n < NOCC; n++)
      begin
        apb(1'b1, ADDR_CTRL, 32'h3);
        wait_rec(1'b1);
        repeat (60) @(posedge clk_sys);
        apb(1'b1, ADDR_CTRL, 32'h5);
        wait_rec(1'b0);
        repeat (60) @(posedge clk_sys);
      end
      nExp = exp_fires(NOCC, f, k, once);
      hl = stp_sync_partner_i.hiLen[1];
      check(stp_sync_partner_i.riseCnt[1] - r1, nExp);
      check(stp_sync_partner_i.fallCnt[2] - f2, 1);
      check({28'h0, syncOut}, 32'h0);
      if (nExp > 0)
        check({31'h0, hl >= w * MSD - 1 && hl <= w * MSD + 1}, 32'h1);
      $display("test output round %0d done", r);
    end
    end_sim();
  end
  // the whole run needs under 1 ms; twice that means a hang
  initial
  begin
    #2_000_000;
    error_cnt++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
bind stp_sync_trigger stp_sync_trigger_props stp_sync_trigger_props_i (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .frameTick(frameTick),
  .syncIn(syncIn), .syncOut(syncOut), .recording(recording));
`default_nettype wire
